// ---- hdl/e1_decode_error_and_signal_loss_monitor.v ----
// Purpose: Line decode error checks, zero run counting and loss of signal monitor
// Assumes: Pulse, recovered clock and amplitude pins are asynchronous to clk
// Notes: Registers reached through a simple strobe port, read data one cycle later
//
// Contract
// R1 - Register bit picks AMI or HDB3 decoding
// R2 - AMI: same polarity pulses flag violation
// R3 - Bipolar violations pulsed to performance monitor
// R4 - HDB3: invalid repeated violations flag code violation
// R5 - Register bit picks zero run definition
// R6 - AMI limits: over 15 or 80 zeros
// R7 - HDB3 over 3, B8ZS over 7 zeros
// R8 - Count zero runs only when field is 01
// R9 - Sixteen bit counter, low and high holding bytes
// R10 - Manual mode: trigger rising edge copies counter
// R11 - Auto mode: copy counter every second
// R12 - Clear after copy, never drop events
// R13 - Counter overflow sets flag, optional interrupt
// R14 - Violations set flag, optional interrupt
// R15 - Zero runs set flag, optional interrupt
// R16 - T1: loss after 175 or 1544 bits
// R17 - E1: loss after 32 or 2048 bits
// R18 - Clear loss needing amplitude and density
// R19 - T1: 16 marks per 128, under 100 zeros
// R20 - E1: 4 marks per 32, under 16 zeros
// R21 - Density judged in non-overlapping blocks
// R22 - Register bit picks short or long criteria
// R23 - Loss flag on rise or any change
// R24 - Loss flag interrupts when enabled
// R25 - All ones replace data during loss
// R26 - Flags latch until cleared, interrupt follows
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`include "e1_monitor_map.vh"

module e1_decode_error_and_signal_loss_monitor
#(
  // Clock cycles per report second
  parameter SECOND_CYCLES = (`REPORT_PERIOD_MS * 1000000) / `CLK_PERIOD_NS
)
(
  // Clock and reset
  input wire clk,
  input wire reset,
  // Line side pins
  input wire posPulseIn,
  input wire negPulseIn,
  input wire lineClkIn,
  input wire belowThresholdIn,
  // Register port
  input wire [3:0] addr,
  input wire [7:0] wrData,
  input wire wrStrobe,
  input wire rdStrobe,
  output reg [7:0] rdData,
  // Outputs to system
  output reg irqOut,
  output reg dataOut,
  output reg dataValid,
  output reg bpvEvent
);

  // Synchroniser stages for the four pins
  reg [3:0] syncA_reg;
  reg [3:0] syncB_reg;
  // Delayed line clock for edge detection
  reg lineClkDly_reg;
  // Software registers
  reg [7:0] lineCtrl_reg;
  reg [7:0] lossCtrl_reg;
  reg [7:0] irqEnable_reg;
  reg [3:0] irqStatus_reg;
  reg [3:0] irqStatus_next;
  // Holding registers for the counter
  reg [15:0] holdCount_reg;
  // Decoder state
  reg lastPol_reg;
  reg lastVPol_reg;
  reg anyPulse_reg;
  reg prevWasBpv_reg;
  reg [7:0] zeroRun_reg;
  reg zeroFlagged_reg;
  // Error counter and report timer
  reg [15:0] errCount_reg;
  reg [15:0] errCount_next;
  reg [31:0] secTimer_reg;
  reg trigPrev_reg;
  // Loss detector state
  reg lossState_reg;
  reg [11:0] belowCount_reg;
  reg [7:0] blockPos_reg;
  reg [7:0] blockMarks_reg;
  reg [7:0] blockRun_reg;
  reg blockBad_reg;

  // Decoded control fields
  wire hdb3Sel = lineCtrl_reg[`BIT_LINE_CODE];
  wire fccSel = lineCtrl_reg[`BIT_ZERO_RULE];
  wire [1:0] zCountField = lineCtrl_reg[`BIT_ZCOUNT_HI:`BIT_ZCOUNT_LO];
  wire autoReport = lineCtrl_reg[`BIT_REPORT_MODE];
  wire trigBit = lineCtrl_reg[`BIT_TRANSFER];
  wire longCrit = lossCtrl_reg[`BIT_LOSS_CRIT];
  wire anyEdgeSel = lossCtrl_reg[`BIT_LOSS_EDGE];
  wire allOnesSel = lossCtrl_reg[`BIT_ALL_ONES];
  wire t1Mode = lossCtrl_reg[`BIT_T1_MODE];

  // Synchronised pin levels, second stage only
  wire posS = syncB_reg[0];
  wire negS = syncB_reg[1];
  wire clkS = syncB_reg[2];
  wire belowS = syncB_reg[3];
  // One bit period per rising recovered clock edge
  wire bitTick = clkS & ~lineClkDly_reg;
  wire mark = posS | negS;
  wire pol = posS;

  // Register write strobes
  wire wrLine = wrStrobe & (addr == `OFS_LINE_CTRL);
  wire wrLoss = wrStrobe & (addr == `OFS_LOSS_CTRL);
  wire wrEn = wrStrobe & (addr == `OFS_IRQ_ENABLE);
  wire wrStat = wrStrobe & (addr == `OFS_IRQ_STATUS);

  // Zero run limit from mode and definition
  function [7:0] zeroLimit;
    input hdb;
    input fcc;
    input t1;
    begin
      if (hdb)
        zeroLimit = t1 ? `ZRUN_B8ZS : `ZRUN_HDB3;
      else
        zeroLimit = fcc ? `ZRUN_AMI_FCC : `ZRUN_AMI_ANSI;
    end
  endfunction

  // Saturating eight bit increment
  function [7:0] inc8;
    input [7:0] v;
    begin
      inc8 = (v == 8'hFF) ? v : v + 8'h01;
    end
  endfunction

  // Event decode for the current bit
  wire bpv = bitTick & mark & anyPulse_reg & (pol == lastPol_reg);
  // Substitution V is valid after two or three zeros with alternating V polarity
  wire vShapeOk = (zeroRun_reg == 8'h02) | (zeroRun_reg == 8'h03);
  wire vValid = vShapeOk & (pol != lastVPol_reg) & ~prevWasBpv_reg;
  // R2 - AMI violation detect
  wire amiViol = ~hdb3Sel & bpv;
  // R4 - HDB3 invalid violation
  wire hdbViol = hdb3Sel & ~t1Mode & bpv & ~vValid;
  wire codeViol = amiViol | hdbViol;
  // R6 - AMI zero limits
  // R7 - HDB3 and B8ZS limits
  wire [7:0] zLimit = zeroLimit(hdb3Sel, fccSel, t1Mode);
  // R5 - Selected definition applied
  wire zeroErr = bitTick & ~mark & ~zeroFlagged_reg & (zeroRun_reg == zLimit);
  // R8 - Count only with field 01
  wire countEvt = zeroErr & (zCountField == `ZCOUNT_ON);

  // Transfer requests
  // R10 - Rising trigger in manual mode
  wire manualXfer = ~autoReport & trigBit & ~trigPrev_reg;
  // R11 - Once per second in auto mode
  wire autoXfer = autoReport & (secTimer_reg == SECOND_CYCLES - 1);
  wire doXfer = manualXfer | autoXfer;
  wire overflow = countEvt & (errCount_reg == 16'hFFFF) & ~doXfer;

  // Loss thresholds per mode and criterion
  // R16 - T1 declaration intervals
  // R17 - E1 declaration intervals
  // R22 - Short or long criterion
  wire [11:0] lossLimit = t1Mode ? (longCrit ? `LOSS_T1_LONG : `LOSS_T1_SHORT)
                                 : (longCrit ? `LOSS_E1_LONG : `LOSS_E1_SHORT);
  wire [7:0] blockLen = t1Mode ? `BLOCK_T1 : `BLOCK_E1;
  wire [7:0] needMarks = t1Mode ? `MARKS_T1 : `MARKS_E1;
  wire [7:0] zeroCap = t1Mode ? `ZEROS_T1 : `ZEROS_E1;
  wire lossDeclare = bitTick & belowS & ~lossState_reg & (belowCount_reg >= lossLimit - 12'h001);
  // Block running values including the current bit
  wire [7:0] marksNow = mark ? inc8(blockMarks_reg) : blockMarks_reg;
  wire [7:0] runNow = mark ? 8'h00 : inc8(blockRun_reg);
  wire badNow = blockBad_reg | belowS | (runNow >= zeroCap);
  wire blockEnd = bitTick & lossState_reg & (blockPos_reg == blockLen - 8'h01);
  // R18 - Amplitude and density both
  // R19 - T1 block density
  // R20 - E1 block density
  wire lossClear = blockEnd & ~badNow & (marksNow >= needMarks);

  // Pin synchronisers
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      syncA_reg <= 4'h0;
      syncB_reg <= 4'h0;
      lineClkDly_reg <= 1'b0;
    end
    else
    begin
      syncA_reg <= {belowThresholdIn, lineClkIn, negPulseIn, posPulseIn};
      syncB_reg <= syncA_reg;
      lineClkDly_reg <= clkS;
    end
  end

  // Control registers
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      lineCtrl_reg <= `RST_LINE_CTRL;
      lossCtrl_reg <= `RST_LOSS_CTRL;
      irqEnable_reg <= `RST_IRQ_ENABLE;
      trigPrev_reg <= 1'b0;
    end
    else
    begin
      // R1 - Line code select stored
      if (wrLine)
        lineCtrl_reg <= wrData;
      if (wrLoss)
        lossCtrl_reg <= wrData;
      if (wrEn)
        irqEnable_reg <= wrData;
      trigPrev_reg <= trigBit;
    end
  end

  // Decoder tracking per bit period
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      lastPol_reg <= 1'b0;
      lastVPol_reg <= 1'b0;
      anyPulse_reg <= 1'b0;
      prevWasBpv_reg <= 1'b0;
      zeroRun_reg <= 8'h00;
      zeroFlagged_reg <= 1'b0;
    end
    else if (bitTick)
    begin
      if (mark)
      begin
        // Pulse resets the zero run
        lastPol_reg <= pol;
        anyPulse_reg <= 1'b1;
        zeroRun_reg <= 8'h00;
        zeroFlagged_reg <= 1'b0;
        prevWasBpv_reg <= bpv & ~vValid;
        if (bpv)
          lastVPol_reg <= pol;
      end
      else
      begin
        // Zero extends the run, one error per run
        zeroRun_reg <= inc8(zeroRun_reg);
        if (zeroErr)
          zeroFlagged_reg <= 1'b1;
      end
    end
  end

  // Error counter next value
  always @*
  begin
    errCount_next = errCount_reg;
    // R12 - Clear on copy, keep event
    if (doXfer)
      errCount_next = countEvt ? 16'h0001 : 16'h0000;
    else if (countEvt)
      errCount_next = errCount_reg + 16'h0001;
  end

  // Counter, report timer and holding registers
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      errCount_reg <= 16'h0000;
      holdCount_reg <= 16'h0000;
      secTimer_reg <= 32'h00000000;
    end
    else
    begin
      // R9 - Sixteen bit accumulate
      errCount_reg <= errCount_next;
      if (doXfer)
        holdCount_reg <= errCount_reg;
      // Timer runs only in auto mode
      if (~autoReport | autoXfer)
        secTimer_reg <= 32'h00000000;
      else
        secTimer_reg <= secTimer_reg + 32'h00000001;
    end
  end

  // Loss detector
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      lossState_reg <= 1'b0;
      belowCount_reg <= 12'h000;
      blockPos_reg <= 8'h00;
      blockMarks_reg <= 8'h00;
      blockRun_reg <= 8'h00;
      blockBad_reg <= 1'b0;
    end
    else if (bitTick)
    begin
      // Count bit periods below the amplitude threshold
      if (belowS)
        belowCount_reg <= (belowCount_reg == 12'hFFF) ? belowCount_reg : belowCount_reg + 12'h001;
      else
        belowCount_reg <= 12'h000;
      if (lossDeclare)
        lossState_reg <= 1'b1;
      else if (lossClear)
        lossState_reg <= 1'b0;
      // R21 - Whole block discarded
      if (~lossState_reg | blockEnd)
      begin
        blockPos_reg <= 8'h00;
        blockMarks_reg <= 8'h00;
        blockRun_reg <= 8'h00;
        blockBad_reg <= 1'b0;
      end
      else
      begin
        blockPos_reg <= blockPos_reg + 8'h01;
        blockMarks_reg <= marksNow;
        blockRun_reg <= runNow;
        blockBad_reg <= badNow;
      end
    end
  end

  // Loss edge for flagging
  wire lossRise = lossDeclare;
  wire lossFall = bitTick & lossClear & lossState_reg;
  // R23 - Rise or any edge
  wire lossEvt = lossRise | (anyEdgeSel & lossFall);

  // Sticky flag next values, set wins over clear
  always @*
  begin
    irqStatus_next = irqStatus_reg;
    if (wrStat)
      irqStatus_next = irqStatus_reg & ~wrData[3:0];
    // R14 - Violation flag set
    if (codeViol)
      irqStatus_next[`BIT_CV] = 1'b1;
    // R15 - Zero run flag set
    if (zeroErr)
      irqStatus_next[`BIT_ZRUN] = 1'b1;
    // R13 - Overflow flag set
    if (overflow)
      irqStatus_next[`BIT_OVF] = 1'b1;
    if (lossEvt)
      irqStatus_next[`BIT_LOSS] = 1'b1;
  end

  // Flags and interrupt output
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irqStatus_reg <= 4'h0;
      irqOut <= 1'b0;
    end
    else
    begin
      // R26 - Latched until cleared
      irqStatus_reg <= irqStatus_next;
      // R24 - Enabled flags drive interrupt
      irqOut <= |(irqStatus_reg & irqEnable_reg[3:0]);
    end
  end

  // Data stream and violation event outputs
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dataOut <= 1'b0;
      dataValid <= 1'b0;
      bpvEvent <= 1'b0;
    end
    else
    begin
      dataValid <= bitTick;
      // R25 - All ones during loss
      if (bitTick)
        dataOut <= (lossState_reg & allOnesSel) ? 1'b1 : mark;
      // R3 - Violation to performance monitor
      bpvEvent <= amiViol | (hdb3Sel & bpv);
    end
  end

  // Register read, data in the following cycle
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      rdData <= 8'h00;
    else if (rdStrobe)
    begin
      case (addr)
        `OFS_LINE_CTRL: rdData <= lineCtrl_reg;
        `OFS_LOSS_CTRL: rdData <= lossCtrl_reg;
        `OFS_IRQ_ENABLE: rdData <= irqEnable_reg;
        `OFS_IRQ_STATUS: rdData <= {4'h0, irqStatus_reg};
        `OFS_LINE_STATUS: rdData <= {7'h00, lossState_reg};
        `OFS_COUNT_LOW: rdData <= holdCount_reg[7:0];
        `OFS_COUNT_HIGH: rdData <= holdCount_reg[15:8];
        // Unmapped reads as zero
        default: rdData <= 8'h00;
      endcase
    end
    else
      rdData <= 8'h00;
  end

endmodule // e1_decode_error_and_signal_loss_monitor

// ---- hdl/e1_monitor_map.vh ----
// Purpose: Offsets, field positions, reset values and counts for the line monitor
// Assumes: 8-bit register data, 4-bit register address
// Notes: Included by the monitor module and the property module
`ifndef E1_MONITOR_MAP_VH
`define E1_MONITOR_MAP_VH

// Register offsets
`define OFS_LINE_CTRL 4'h0
`define OFS_LOSS_CTRL 4'h1
`define OFS_IRQ_ENABLE 4'h2
`define OFS_IRQ_STATUS 4'h3
`define OFS_LINE_STATUS 4'h4
`define OFS_COUNT_LOW 4'h5
`define OFS_COUNT_HIGH 4'h6

// Line control fields
`define BIT_LINE_CODE 0
`define BIT_ZERO_RULE 1
`define BIT_ZCOUNT_LO 2
`define BIT_ZCOUNT_HI 3
`define BIT_REPORT_MODE 4
`define BIT_TRANSFER 5
`define ZCOUNT_ON 2'h1

// Loss control fields
`define BIT_LOSS_CRIT 0
`define BIT_LOSS_EDGE 1
`define BIT_ALL_ONES 2
`define BIT_T1_MODE 3

// Interrupt status and enable fields
`define BIT_CV 0
`define BIT_ZRUN 1
`define BIT_OVF 2
`define BIT_LOSS 3

// Reset values
`define RST_LINE_CTRL 8'h00
`define RST_LOSS_CTRL 8'h00
`define RST_IRQ_ENABLE 8'h00

// Zero run limits
`define ZRUN_AMI_ANSI 8'h0F
`define ZRUN_AMI_FCC 8'h50
`define ZRUN_HDB3 8'h03
`define ZRUN_B8ZS 8'h07

// Loss declaration intervals in bit periods
`define LOSS_E1_SHORT 12'h020
`define LOSS_E1_LONG 12'h800
`define LOSS_T1_SHORT 12'h0AF
`define LOSS_T1_LONG 12'h608

// Density blocks for clearing loss
`define BLOCK_E1 8'h20
`define MARKS_E1 8'h04
`define ZEROS_E1 8'h10
`define BLOCK_T1 8'h80
`define MARKS_T1 8'h10
`define ZEROS_T1 8'h64

// Report period
`define CLK_PERIOD_NS 40
`define REPORT_PERIOD_MS 1000

`endif

// ---- test/e1_monitor_properties.sv ----
// Purpose: Port-level properties of the line monitor
// Assumes: One clock, reset asynchronous and active high
// Notes: Bound to the monitor top module
`timescale 1ns/10ps
`include "e1_monitor_map.vh"
module e1_monitor_properties
(
  // Clock and reset
  input wire clk,
  input wire reset,
  // Line side pins
  input wire posPulseIn,
  input wire negPulseIn,
  input wire lineClkIn,
  input wire belowThresholdIn,
  // Register port
  input wire [3:0] addr,
  input wire [7:0] wrData,
  input wire wrStrobe,
  input wire rdStrobe,
  input wire [7:0] rdData,
  // Outputs to system
  input wire irqOut,
  input wire dataOut,
  input wire dataValid,
  input wire bpvEvent
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Read of the line status byte
  sequence s_status_rd;
    rdStrobe && addr == `OFS_LINE_STATUS;
  endsequence
  // Read above the last mapped offset
  sequence s_unmapped_rd;
    rdStrobe && addr > `OFS_COUNT_HIGH;
  endsequence
  a_rd_idle_zero: assert property (!$past(rdStrobe) |-> rdData == 8'h00)
    else $error("read data not idle");
  a_status_upper_zero: assert property (s_status_rd |=> rdData[7:1] == 7'h00)
    else $error("status upper bits set");
  a_unmapped_zero: assert property (s_unmapped_rd |=> rdData == 8'h00)
    else $error("unmapped read not zero");
  a_bpv_on_tick: assert property (bpvEvent |-> dataValid)
    else $error("violation event off tick");
  a_bpv_one_cycle: assert property (bpvEvent |=> !bpvEvent)
    else $error("violation event too long");
  a_valid_one_cycle: assert property (dataValid |=> !dataValid)
    else $error("data valid too long");
  a_data_on_tick: assert property ($changed(dataOut) |-> dataValid)
    else $error("data changed off tick");
  a_tick_after_edge: assert property ($rose(dataValid) |-> $past(lineClkIn, 3) || $past(lineClkIn, 4))
    else $error("tick without line clock");
  a_irq_fall_cause: assert property ($fell(irqOut) |-> $past(wrStrobe) || $past(wrStrobe, 2))
    else $error("interrupt dropped by itself");
  a_irq_rise_cause: assert property ($rose(irqOut) |-> $past(dataValid) || $past(wrStrobe, 2))
    else $error("interrupt without cause");
endmodule // e1_monitor_properties

bind e1_decode_error_and_signal_loss_monitor e1_monitor_properties props (.clk(clk), .reset(reset),
  .posPulseIn(posPulseIn), .negPulseIn(negPulseIn), .lineClkIn(lineClkIn), .belowThresholdIn(belowThresholdIn),
  .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
  .irqOut(irqOut), .dataOut(dataOut), .dataValid(dataValid), .bpvEvent(bpvEvent));

// ---- test/line_slicer_model.sv ----
// Purpose: Data slicer model delivering bipolar pulses and recovered clock
// Assumes: Line clock stands still low between bits
// Notes: Pulses are inverted once the sampling phase is over
`timescale 1ns/10ps
module line_slicer_model
(
  // Clock
  input wire clk,
  // Line side pins
  output reg posPulseIn,
  output reg negPulseIn,
  output reg lineClkIn,
  output reg belowThresholdIn
);
  // Idle line
  initial
  begin
    posPulseIn = 1'b0;
    negPulseIn = 1'b0;
    lineClkIn = 1'b0;
    belowThresholdIn = 1'b0;
  end
  // One bit: clock high three cycles, low three
  task send_bit(input p, input n, input b);
    begin
      @(posedge clk);
      lineClkIn <= 1'b1;
      posPulseIn <= p;
      negPulseIn <= n;
      belowThresholdIn <= b;
      repeat (3) @(posedge clk);
      // Pulses no longer valid, show inverse
      lineClkIn <= 1'b0;
      posPulseIn <= !p;
      negPulseIn <= !n;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule // line_slicer_model

// ---- test/tb_e1_decode_error_and_signal_loss_monitor.sv ----
// Purpose: Self-checking bench for the line monitor
// Assumes: Short report second, slicer model on the line pins
// Notes: Expected counts kept in bench integers
`timescale 1ns/10ps
module tb_e1_decode_error_and_signal_loss_monitor;
  // Bench drives
  reg clk, reset, wrStrobe, rdStrobe, pol;
  reg [3:0] addr;
  reg [7:0] wrData, v;
  wire [7:0] rdData;
  wire irqOut, dataOut, dataValid, bpvEvent, posPulseIn, negPulseIn, lineClkIn, belowThresholdIn;
  // Counters and tables
  integer miscompares, cmp_count, bpvSeen, expZ, i, k;
  reg [7:0] zCtrl [0:3];
  integer zLim [0:3];
  integer zCnt [0:3];
  // Device under test
  e1_decode_error_and_signal_loss_monitor #(.SECOND_CYCLES(200)) dut (.clk(clk), .reset(reset),
    .posPulseIn(posPulseIn), .negPulseIn(negPulseIn), .lineClkIn(lineClkIn), .belowThresholdIn(belowThresholdIn),
    .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .irqOut(irqOut), .dataOut(dataOut), .dataValid(dataValid), .bpvEvent(bpvEvent));
  // Far side slicer
  line_slicer_model slicer (.clk(clk), .posPulseIn(posPulseIn), .negPulseIn(negPulseIn),
    .lineClkIn(lineClkIn), .belowThresholdIn(belowThresholdIn));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Violation event counter
  always @(posedge clk)
    if (bpvEvent === 1'b1)
      bpvSeen = bpvSeen + 1;
  task check(input [15:0] seen, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        miscompares = miscompares + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrStrobe <= 1'b1;
      @(posedge clk);
      wrStrobe <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, output [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      rdStrobe <= 1'b1;
      @(posedge clk);
      rdStrobe <= 1'b0;
      #1 d = rdData;
    end
  endtask
  // Bits: zeros or alternating marks
  task bits(input integer n, input m, input b);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1)
      begin
        pol = m ? !pol : pol;
        slicer.send_bit(m & pol, m & !pol, b);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Watchdog
  initial
  begin
    #1600000;
    miscompares = miscompares + 1;
    tally_and_finish;
  end
  // Main sequence
  initial
  begin
    {reset, wrStrobe, rdStrobe, addr, wrData} = {1'b1, 14'h0000};
    {miscompares, cmp_count, bpvSeen, expZ} = 0;
    {zCtrl[0], zCtrl[1], zCtrl[2], zCtrl[3]} = {8'h04, 8'h06, 8'h05, 8'h00};
    {zLim[0], zLim[1], zLim[2], zLim[3]} = {32'd15, 32'd80, 32'd3, 32'd15};
    {zCnt[0], zCnt[1], zCnt[2], zCnt[3]} = {32'd1, 32'd1, 32'd1, 32'd0};
    i = $urandom(17);
    pol = $urandom % 2;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    // Reset values, unmapped offset last
    for (i = 0; i < 8; i = i + 1)
    begin
      rd((i == 7) ? 4'hF : i[3:0], v);
      check(v, 16'h0000);
    end
    $display("test 1 done");
    // Same polarity twice under AMI
    bits(2, 1'b1, 1'b0);
    wr(4'h3, 8'h0F);
    wr(4'h2, 8'h01);
    bpvSeen = 0;
    slicer.send_bit(pol, !pol, 1'b0);
    check(bpvSeen, 16'h0001);
    rd(4'h3, v);
    check(v, 16'h0001);
    check(irqOut, 16'h0001);
    wr(4'h3, 8'h01);
    repeat (3) @(posedge clk);
    check(irqOut, 16'h0000);
    // Same polarity right after a mark under HDB3 is no substitution
    wr(4'h0, 8'h01);
    slicer.send_bit(pol, !pol, 1'b0);
    check(bpvSeen, 16'h0002);
    rd(4'h3, v);
    check(v & 8'h01, 16'h0001);
    wr(4'h0, 8'h00);
    $display("test 2 done");
    // Zero run limits per code and definition
    for (k = 0; k < 4; k = k + 1)
    begin
      wr(4'h0, zCtrl[k]);
      bits(1, 1'b1, 1'b0);
      wr(4'h3, 8'h0F);
      bits(zLim[k], 1'b0, 1'b0);
      rd(4'h3, v);
      check(v & 8'h02, 16'h0000);
      bits(1, 1'b0, 1'b0);
      rd(4'h3, v);
      check(v & 8'h02, 16'h0002);
      expZ = expZ + zCnt[k];
    end
    // Manual transfer, then counter cleared
    wr(4'h0, 8'h24);
    rd(4'h5, v);
    check(v, expZ);
    rd(4'h6, v);
    check(v, 16'h0000);
    wr(4'h0, 8'h04);
    wr(4'h0, 8'h24);
    rd(4'h5, v);
    check(v, 16'h0000);
    $display("test 3 done");
    // Loss declare and clear: E1 short, E1 long, then T1 short
    for (k = 0; k < 3; k = k + 1)
    begin
      wr(4'h0, 8'h00);
      wr(4'h1, (k == 2) ? 8'h0E : (k ? 8'h05 : 8'h06));
      wr(4'h2, 8'h08);
      wr(4'h3, 8'h0F);
      bits((k == 2) ? 174 : (k ? 2047 : 31), 1'b0, 1'b1);
      rd(4'h4, v);
      check(v, 16'h0000);
      bits(1, 1'b0, 1'b1);
      rd(4'h4, v);
      check(v, 16'h0001);
      rd(4'h3, v);
      check(v & 8'h08, 16'h0008);
      check(irqOut, 16'h0001);
      // One more low bit while loss stands, forced to one
      bits(1, 1'b0, 1'b1);
      check(dataOut, 16'h0001);
      wr(4'h3, 8'h0F);
      // First block holds the low bit and is thrown away
      bits((k == 2) ? 256 : 64, 1'b1, 1'b0);
      rd(4'h4, v);
      check(v, 16'h0000);
      rd(4'h3, v);
      check(v & 8'h08, (k == 1) ? 16'h0000 : 16'h0008);
    end
    $display("test 4 done");
    tally_and_finish;
  end
endmodule // tb_e1_decode_error_and_signal_loss_monitor
